// *** common/cis_pkg.sv ***
/*
 * Constants for the card information structure block: structure layout,
 * configuration register block, configuration indexes, decode ranges and
 * register map on the Avalon-MM slave.
 * Assumes a single 40 MHz clock and a synchronous active-low reset.
 */
package cis_pkg;

    // ****************************************************************
    // Structure storage
    // ****************************************************************
    localparam int          CIS_BYTES     = 98;
    localparam int          CIS_IDX_W     = 7;
    localparam logic [11:0] CIS_BASE      = 12'h040;
    localparam logic [11:0] CFG_REG_BASE  = 12'h200;
    localparam logic [7:0]  CFG_PRESENT   = 8'h0F;
    localparam logic [7:0]  LAST_INDEX    = 8'h07;
    localparam logic [11:0] IFTYPE_ADDR   = 12'h038;
    localparam logic [7:0]  IFTYPE_ATA    = 8'h01;

    // ****************************************************************
    // Configuration indexes
    // ****************************************************************
    localparam logic [5:0]  IDX_MEM       = 6'h00;
    localparam logic [5:0]  IDX_IO_ANY    = 6'h01;
    localparam logic [5:0]  IDX_IO_PRI    = 6'h02;
    localparam logic [5:0]  IDX_IO_SEC    = 6'h03;

    // ****************************************************************
    // Decode ranges
    // ****************************************************************
    localparam logic [9:0]  PRI_TASK_LO   = 10'h1F0;
    localparam logic [9:0]  PRI_TASK_HI   = 10'h1F7;
    localparam logic [9:0]  PRI_CTRL_LO   = 10'h3F6;
    localparam logic [9:0]  PRI_CTRL_HI   = 10'h3F7;
    localparam logic [9:0]  SEC_TASK_LO   = 10'h170;
    localparam logic [9:0]  SEC_TASK_HI   = 10'h177;
    localparam logic [9:0]  SEC_CTRL_LO   = 10'h376;
    localparam logic [9:0]  SEC_CTRL_HI   = 10'h377;
    localparam int          ANY_LINES     = 4;
    localparam logic [3:0]  FIXED_IRQ     = 4'hE;
    localparam logic [10:0] MEM_SPAN      = 11'h7FF;

    // ****************************************************************
    // Avalon-MM register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] REG_COR       = 12'h200;
    localparam logic [11:0] REG_CSR       = 12'h204;
    localparam logic [11:0] REG_IOCHK     = 12'h208;
    localparam logic [11:0] REG_STATUS    = 12'h20C;
    localparam int          IDX_LSB       = 0;
    localparam int          LEVIRQ_BIT    = 6;
    localparam int          SRESET_BIT    = 7;
    localparam int          PWRDN_BIT     = 2;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [4:0] {
        CIS_MODE_MEM = 5'b00001,
        CIS_MODE_ANY = 5'b00010,
        CIS_MODE_PRI = 5'b00100,
        CIS_MODE_SEC = 5'b01000,
        CIS_MODE_OFF = 5'b10000
    } cis_mode_e;

endpackage : cis_pkg

// *** verilog/cis_cfg_decode.sv ***
/*
 * Card information structure (attribute memory, basic disk features tuple
 * through the configuration table) plus the per-index address decode and
 * interrupt behaviour. Reached over Avalon-MM with waitrequest.
 * Assumes the host reads the structure, then writes one advertised index.
 */
// Notes on behaviour
// - single drive, no serial, silicon, no VPP
// - sleep, standby, idle supported, value seven
// - decode includes 0x3F7, index not emulated
// - last configuration entry index is seven
// - config registers at 0200h, 2-byte base field
// - config registers zero to three present
// - index zero uses wait and ready/busy
// - index zero no IRQ/IO, 2 KByte memory
// - I/O indexes: no wait, ready/busy active
// - index one decodes four lines, 8/16-bit
// - index one IRQ any line, masks FFh
// - I/O IRQ sharing, pulse and level modes
// - indexes two, three decode ten lines
// - index two task file 1F0-1F7
// - index two control 3F6-3F7
// - indexes two, three use IRQ fourteen
// - index three task file 170-177
// - index three control 376-377
// - power-down, read/write, no audio, one twin
// - disk interface type is card ATA
module cis_cfg_decode
    import cis_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Avalon-MM slave, byte address
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Host access qualification
    input  wire logic [10:0] host_addr,
    input  wire logic        host_iord,
    input  wire logic        host_memrd,
    input  wire logic        host_busy_in,
    input  wire logic        host_irq_in,
    // Decode and signalling outputs
    output logic             io_hit,
    output logic             mem_hit,
    output logic             wait_used,
    output logic             rdy_bsy_n,
    output logic             irq_level_n,
    output logic             irq_pulse,
    output logic [3:0]       irq_line,
    output logic             io_is16_n,
    output logic [4:0]       cfg_mode
);
    import cis_pkg::*;

    // ****************************************************************
    // Structure contents, 0x040 onward, one byte per even address
    // ****************************************************************
    localparam logic [7:0] CIS_ROM [CIS_BYTES] = '{
        8'h04, 8'h07, 8'h1A, 8'h05, 8'h01, 8'h07, 8'h00, 8'h02,
        8'h0F, 8'h1B, 8'h0B, 8'hC0, 8'hC0, 8'hA1, 8'h27, 8'h55,
        8'h4D, 8'h5D, 8'h75, 8'h08, 8'h00, 8'h21, 8'h1B, 8'h06,
        8'h00, 8'h01, 8'h21, 8'hB5, 8'h1E, 8'h4D, 8'h1B, 8'h0D,
        8'hC1, 8'h41, 8'h99, 8'h27, 8'h55, 8'h4D, 8'h5D, 8'h75,
        8'h64, 8'hF0, 8'hFF, 8'hFF, 8'h21, 8'h1B, 8'h06, 8'h01,
        8'h01, 8'h21, 8'hB5, 8'h1E, 8'h4D, 8'h1B, 8'h12, 8'hC2,
        8'h41, 8'h99, 8'h27, 8'h55, 8'h4D, 8'h5D, 8'h75, 8'hEA,
        8'h61, 8'hF0, 8'h01, 8'h07, 8'hF6, 8'h03, 8'h01, 8'hEE,
        8'h21, 8'h1B, 8'h06, 8'h02, 8'h01, 8'h21, 8'hB5, 8'h1E,
        8'h4D, 8'h1B, 8'h12, 8'hC3, 8'h41, 8'h99, 8'h27, 8'h55,
        8'h4D, 8'h5D, 8'h75, 8'hEA, 8'h61, 8'h70, 8'h01, 8'h07,
        8'h76, 8'h03
    };
    // Entries: 0:1:5:6-7:8:12:13,19
    // 33:40:41-43:63:65-70:71
    // 21:linking bytes carry each tuple length

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0] rdata;
        logic        wait_n;
        logic        busy;
        logic [5:0]  cfg_idx;
        logic        lev_irq;
        logic        pwr_dn;
        logic        io_hit;
        logic        mem_hit;
        logic        wait_used;
        logic        rdy_bsy_n;
        logic        irq_level_n;
        logic        irq_pulse;
        logic [3:0]  irq_line;
        logic        io_is16_n;
        logic        irq_prev;
        logic [4:0]  mode;
    } cis_state_s;

    cis_state_s st_r;
    cis_state_s st_nxt;

    cis_mode_e   mode_now;
    logic [11:0] rel_addr;
    logic [6:0]  rom_idx;
    logic        in_cis;
    logic [9:0]  a10;
    logic        io_dec;

    // ****************************************************************
    // Combinational next state
    // ****************************************************************
    always_comb begin
        st_nxt   = st_r;
        rel_addr = avs_address - CIS_BASE;
        rom_idx  = rel_addr[CIS_IDX_W:1];
        in_cis   = (avs_address >= CIS_BASE) && !avs_address[0]
                   && (rel_addr[11:1] < 11'(CIS_BYTES));
        a10      = host_addr[9:0];

        case (st_r.cfg_idx)
            IDX_MEM:    mode_now = CIS_MODE_MEM;
            IDX_IO_ANY: mode_now = CIS_MODE_ANY;
            IDX_IO_PRI: mode_now = CIS_MODE_PRI;
            IDX_IO_SEC: mode_now = CIS_MODE_SEC;
            default:    mode_now = CIS_MODE_OFF;
        endcase

        // Bus slave: one wait cycle, answer on the second edge
        st_nxt.wait_n = 1'b0;
        if ((avs_read || avs_write) && !st_r.busy) begin
            st_nxt.busy   = 1'b1;
            st_nxt.wait_n = 1'b1;
            st_nxt.rdata  = UNMAPPED_DATA;
            if (avs_read) begin
                if (in_cis)
                    st_nxt.rdata = {24'h0, CIS_ROM[rom_idx]};
                else if (avs_address == IFTYPE_ADDR)
                    st_nxt.rdata = {24'h0, IFTYPE_ATA};
                else if (avs_address == REG_COR)
                    st_nxt.rdata = {24'h0, st_r.lev_irq, 1'b0, st_r.cfg_idx};
                else if (avs_address == REG_CSR)
                    st_nxt.rdata = {29'h0, st_r.pwr_dn, 2'h0};
                else if (avs_address == REG_STATUS)
                    st_nxt.rdata = {27'h0, st_r.mode};
            end
        end else if (st_r.busy) begin
            st_nxt.busy = 1'b0;
            // Write lands on the edge at which the master sees waitrequest low
            if (avs_write && avs_byteenable[0]) begin
                // Structure is read-only; writes there are dropped
                if (avs_address == REG_COR) begin
                    st_nxt.cfg_idx = avs_writedata[5:0];
                    st_nxt.lev_irq = avs_writedata[LEVIRQ_BIT];
                    if (avs_writedata[SRESET_BIT]) begin
                        st_nxt.cfg_idx = IDX_MEM;
                        st_nxt.lev_irq = 1'b0;
                    end
                end else if (avs_address == REG_CSR) begin
                    st_nxt.pwr_dn = avs_writedata[PWRDN_BIT];
                end
            end
        end

        // Address decode per configuration
        io_dec = 1'b0;
        case (mode_now)
            CIS_MODE_ANY: io_dec = host_iord;
            CIS_MODE_PRI: io_dec = host_iord
                && (((a10 >= PRI_TASK_LO) && (a10 <= PRI_TASK_HI))
                 || ((a10 >= PRI_CTRL_LO) && (a10 <= PRI_CTRL_HI)));
            CIS_MODE_SEC: io_dec = host_iord
                && (((a10 >= SEC_TASK_LO) && (a10 <= SEC_TASK_HI))
                 || ((a10 >= SEC_CTRL_LO) && (a10 <= SEC_CTRL_HI)));
            CIS_MODE_MEM: io_dec = 1'b0;
            default:      io_dec = 1'b0;
        endcase
        st_nxt.io_hit    = io_dec;
        st_nxt.io_is16_n = !io_dec;
        st_nxt.mem_hit   = (mode_now == CIS_MODE_MEM) && host_memrd
                           && (host_addr <= MEM_SPAN);
        st_nxt.wait_used = (mode_now == CIS_MODE_MEM);
        st_nxt.rdy_bsy_n = !host_busy_in;
        st_nxt.mode      = mode_now;

        // Interrupt: none in memory mode or an unadvertised index, shared level or pulse for the I/O indexes
        st_nxt.irq_prev = host_irq_in;
        st_nxt.irq_level_n = 1'b1;
        st_nxt.irq_pulse   = 1'b0;
        if (mode_now != CIS_MODE_MEM && mode_now != CIS_MODE_OFF) begin
            st_nxt.irq_level_n = !(st_r.lev_irq && host_irq_in);
            st_nxt.irq_pulse   = !st_r.lev_irq && host_irq_in
                                 && !st_r.irq_prev;
        end
        // Any host line for index one, fixed fourteen for two and three
        st_nxt.irq_line = (mode_now == CIS_MODE_PRI || mode_now == CIS_MODE_SEC)
                          ? FIXED_IRQ : 4'h0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r             <= '0;
            st_r.rdy_bsy_n   <= 1'b1;
            st_r.irq_level_n <= 1'b1;
            st_r.io_is16_n   <= 1'b1;
            st_r.wait_used   <= 1'b1;
            st_r.mode        <= CIS_MODE_MEM;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata    = st_r.rdata;
    assign avs_waitrequest = !st_r.wait_n;
    assign io_hit          = st_r.io_hit;
    assign mem_hit         = st_r.mem_hit;
    assign wait_used       = st_r.wait_used;
    assign rdy_bsy_n       = st_r.rdy_bsy_n;
    assign irq_level_n     = st_r.irq_level_n;
    assign irq_pulse       = st_r.irq_pulse;
    assign irq_line        = st_r.irq_line;
    assign io_is16_n       = st_r.io_is16_n;
    assign cfg_mode        = st_r.mode;

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_PRI_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_PRI && host_iord && host_addr[9:0] == 10'h1F0)
        |=> io_hit) else $error("primary task file not decoded");
    AST_PRI_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_PRI && host_iord && host_addr[9:0] == 10'h3F7)
        |=> io_hit) else $error("primary control not decoded");
    AST_SEC_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_SEC && host_iord && host_addr[9:0] == 10'h1F0)
        |=> !io_hit) else $error("secondary decoded primary address");
    AST_SEC_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_SEC && host_iord && host_addr[9:0] == 10'h376)
        |=> io_hit) else $error("secondary control not decoded");
    AST_MEM_NOIO: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_MEM) |=> !io_hit && irq_level_n && !irq_pulse)
        else $error("memory mode used I/O or interrupt");
    AST_WAIT_USE: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_MEM) |=> wait_used) else $error("wait not used");
    AST_IO_NOWAIT: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_ANY) |=> !wait_used) else $error("wait in I/O mode");
    AST_IRQ14: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_SEC) |=> irq_line == 4'hE)
        else $error("wrong interrupt line");
    AST_ANY_DEC: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_ANY && host_iord) |=> io_hit && !io_is16_n)
        else $error("index one decode missed");
    AST_BUS_ANS: assert property (@(posedge clk) disable iff (!rst_n)
        ((avs_read || avs_write) && avs_waitrequest && !st_r.busy)
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not in one cycle");
    AST_CIS_LAST: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read && avs_address == 12'h04A && avs_waitrequest && !st_r.busy)
        |=> avs_readdata == 32'h7) else $error("last index byte wrong");
    AST_IFTYPE: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read && avs_address == IFTYPE_ADDR && avs_waitrequest && !st_r.busy)
        |=> avs_readdata == {24'h0, IFTYPE_ATA}) else $error("interface type byte wrong");
    AST_RDY_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        host_busy_in |=> !rdy_bsy_n) else $error("ready/busy not following engine");
    AST_PRI_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_PRI) |=> irq_line == FIXED_IRQ)
        else $error("primary interrupt line wrong");
    AST_ANY_LINE: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cfg_idx == IDX_IO_ANY) |=> irq_line == 4'h0)
        else $error("index one line not left to host");

endmodule : cis_cfg_decode

// *** test/cis_host_model.sv ***
/*
 * Host socket controller model: turns one bench request into one host strobe cycle.
 * Assumes the bench raises req for one clock per access, only after configuring.
 */
module cis_host_model (
    // Clock
    input  wire logic        clk,
    // Bench requests
    input  wire logic        req,
    input  wire logic [10:0] req_addr,
    input  wire logic        req_io,
    // Host side of the block
    output logic [10:0]      host_addr,
    output logic             host_iord,
    output logic             host_memrd
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [10:0] addr_q  = 11'h000;
    logic        iord_q  = 1'b0;
    logic        memrd_q = 1'b0;

    assign host_addr  = addr_q;
    assign host_iord  = iord_q;
    assign host_memrd = memrd_q;

    always @(posedge clk) begin
        if (req) begin
            addr_q  <= req_addr;
            iord_q  <= req_io;
            memrd_q <= !req_io;
        end else begin
            // Released bus: flip the address so a stale value never decodes by luck
            addr_q  <= ~addr_q;
            iord_q  <= 1'b0;
            memrd_q <= 1'b0;
        end
    end
endmodule : cis_host_model

// *** test/card_info_structure_config_decode_tb.sv ***
/*
 * Self-checking bench: structure reads over Avalon-MM, index writes, host decode.
 * Assumes cis_pkg and the host model in cis_host_model.sv.
 */
module card_info_structure_config_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cis_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [10:0] host_addr;
    logic [10:0] req_addr = 11'h000;
    logic        host_iord, host_memrd, req = 1'b0, req_io = 1'b0;
    logic        host_busy_in = 1'b0, host_irq_in = 1'b0;
    logic        io_hit, mem_hit, wait_used, rdy_bsy_n, irq_level_n, irq_pulse, io_is16_n;
    logic [3:0]  irq_line;
    logic [4:0]  cfg_mode;
    logic [31:0] exp_q[$];
    int          mismatches = 0;
    int          total_checks = 0;
    // Address and expected byte of each location probed: structure bytes, an odd address, an unmapped address and the interface type
    localparam logic [19:0] CIS_TAB [0:45] = '{
        20'h040_04, 20'h042_07,
        20'h04A_07, 20'h048_01, 20'h04C_00, 20'h04E_02,
        20'h050_0F, 20'h058_C0, 20'h05A_A1, 20'h066_08, 20'h068_00,
        20'h082_41, 20'h0B0_41, 20'h0E8_41, 20'h090_64,
        20'h094_FF, 20'h096_FF, 20'h092_F0, 20'h0CE_EE,
        20'h0BE_EA, 20'h0C2_F0, 20'h0C4_01, 20'h0C6_07,
        20'h0C8_F6, 20'h0CA_03, 20'h0CC_01, 20'h06A_21,
        20'h0F6_EA, 20'h0FA_70, 20'h0FC_01, 20'h0FE_07,
        20'h100_76, 20'h102_03, 20'h0D0_21, 20'h098_21,
        20'h046_05, 20'h054_0B, 20'h06E_06, 20'h07E_0D, 20'h09C_06, 20'h0AC_12,
        20'h0D4_06, 20'h0E4_12, 20'h041_00, 20'h300_00, 20'h038_01};
    localparam logic [9:0] PRI_PROBE [0:7] = '{10'h1F0, 10'h1F7, 10'h3F6, 10'h3F7,
        10'h1EF, 10'h1F8, 10'h3F5, 10'h170};
    localparam logic [9:0] SEC_PROBE [0:7] = '{10'h170, 10'h177, 10'h376, 10'h377,
        10'h16F, 10'h178, 10'h375, 10'h1F0};

    always #12.5 clk = ~clk;

    cis_cfg_decode uut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .host_addr(host_addr), .host_iord(host_iord), .host_memrd(host_memrd),
        .host_busy_in(host_busy_in), .host_irq_in(host_irq_in), .io_hit(io_hit),
        .mem_hit(mem_hit), .wait_used(wait_used), .rdy_bsy_n(rdy_bsy_n),
        .irq_level_n(irq_level_n), .irq_pulse(irq_pulse), .irq_line(irq_line),
        .io_is16_n(io_is16_n), .cfg_mode(cfg_mode));
    cis_host_model host (.clk(clk), .req(req), .req_addr(req_addr), .req_io(req_io),
        .host_addr(host_addr), .host_iord(host_iord), .host_memrd(host_memrd));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Read data is judged by the watcher below, in issue order
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            check(avs_readdata, exp_q.pop_front());
        end
    end

    task automatic avs_xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0) begin
            mismatches++;
            conclude();
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : avs_xfer

    task automatic avs_rd(input logic [11:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        avs_xfer(a, 1'b0, 32'h0);
    endtask : avs_rd

    task automatic set_cfg(input logic [5:0] idx, input logic lvl);
        avs_xfer(REG_COR, 1'b1, {24'h0, 1'b0, lvl, idx});
        repeat (2) @(posedge clk);
        #1;
        check(32'(cfg_mode), (idx < 6'h04) ? 32'(5'h01 << idx) : 32'h10);
        check(32'(wait_used), 32'(idx == IDX_MEM));
        check(32'(irq_line), (idx == IDX_IO_PRI || idx == IDX_IO_SEC) ?
            32'(FIXED_IRQ) : 32'h0);
    endtask : set_cfg

    task automatic host_acc(input logic [10:0] a, input logic io, input logic hit);
        @(posedge clk);
        req      <= 1'b1;
        req_addr <= a;
        req_io   <= io;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1;
        check(32'(io ? io_hit : mem_hit), 32'(hit));
        check(32'(io ? mem_hit : io_hit), 32'h0);
        check(32'(io_is16_n), 32'(!(io && hit)));
    endtask : host_acc

    task automatic irq_try(input logic pulse_exp, input logic lvl_n_exp);
        @(posedge clk);
        host_irq_in <= 1'b1;
        @(posedge clk);
        #1;
        check(32'(irq_pulse), 32'(pulse_exp));
        check(32'(irq_level_n), 32'(lvl_n_exp));
        @(posedge clk);
        #1;
        check(32'(irq_pulse), 32'h0);
        @(posedge clk);
        host_irq_in <= 1'b0;
        @(posedge clk);
        #1;
        check(32'(irq_level_n), 32'h1);
    endtask : irq_try

    initial begin
        logic b;
        void'($urandom(32'hA768));
        repeat (11) @(posedge clk);
        #1;
        check(32'(cfg_mode), 32'h01);
        check(32'(avs_waitrequest), 32'h1);
        @(posedge clk);
        rst_n <= 1'b1;
        foreach (CIS_TAB[i]) avs_rd(CIS_TAB[i][19:8], {24'h0, CIS_TAB[i][7:0]});
        avs_xfer(12'h042, 1'b1, 32'h0000_00FF);
        avs_rd(12'h042, 32'h0000_0007);
        avs_rd(REG_IOCHK, 32'h0);
        // Memory-mapped index: memory hits only, interrupt silent
        set_cfg(IDX_MEM, 1'b0);
        host_acc(11'($urandom) & MEM_SPAN, 1'b0, 1'b1);
        host_acc(11'h1F0, 1'b1, 1'b0);
        irq_try(1'b0, 1'b1);
        // Any-address I/O index
        set_cfg(IDX_IO_ANY, 1'b0);
        repeat (4) host_acc(11'($urandom), 1'b1, 1'b1);
        repeat (4) begin
            b = 1'($urandom);
            @(posedge clk);
            host_busy_in <= b;
            @(posedge clk);
            #1;
            check(32'(rdy_bsy_n), 32'(!b));
        end
        irq_try(1'b1, 1'b1);
        // Primary and secondary ranges, both interrupt modes on the primary index only
        set_cfg(IDX_IO_PRI, 1'b0);
        for (int i = 0; i < 8; i++) host_acc({1'b0, PRI_PROBE[i]}, 1'b1, i < 4);
        irq_try(1'b1, 1'b1);
        set_cfg(IDX_IO_PRI, 1'b1);
        irq_try(1'b0, 1'b0);
        set_cfg(IDX_IO_SEC, 1'b0);
        for (int i = 0; i < 8; i++) host_acc({1'b0, SEC_PROBE[i]}, 1'b1, i < 4);
        // Unadvertised index decodes nothing
        set_cfg(6'h05, 1'b0);
        host_acc(11'h1F0, 1'b1, 1'b0);
        // Low byte lane off: the index write must be ignored
        avs_byteenable <= 4'hE;
        avs_xfer(REG_COR, 1'b1, 32'h0000_0002);
        avs_byteenable <= 4'hF;
        avs_rd(REG_COR, 32'h0000_0005);
        avs_rd(REG_STATUS, 32'h0000_0010);
        avs_xfer(REG_CSR, 1'b1, 32'h0000_0004);
        avs_rd(REG_CSR, 32'h0000_0004);
        // Soft reset bit returns to the memory-mapped index
        avs_xfer(REG_COR, 1'b1, 32'h0000_0080);
        avs_rd(REG_COR, 32'h0000_0000);
        avs_rd(REG_STATUS, 32'h0000_0001);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : card_info_structure_config_decode_tb
